// ### common/wake_watchdog_trim_pkg.sv
// package: offsets, field positions, reset values and timing counts for the wake/watchdog/trim bank
package wake_watchdog_trim_pkg;
  // byte addresses of the external register space (16-bit address)
  localparam logic [15:0] WD_STATUS_ADDR = 16'h2002;
  localparam logic [15:0] REF_CTRL_ADDR = 16'h2004;
  localparam logic [15:0] REVISION_ADDR = 16'h2006;
  localparam logic [15:0] RTC_UNLOCK_ADDR = 16'h201F;
  localparam logic [15:0] WAKE_CTRL_ADDR = 16'h20A9;
  localparam logic [15:0] NEAR_FLAG_ADDR = 16'h20B1;
  localparam logic [15:0] FUSE_SEL_ADDR = 16'h20FD;
  localparam logic [15:0] FUSE_DATA_ADDR = 16'h20FF;
  localparam logic [15:0] ERASE_LOCK_ADDR = 16'h00B2;
  localparam logic [15:0] WD_RESTART_ADDR = 16'h00F8;
  localparam logic [15:0] INT_STATUS_ADDR = 16'h2100;
  localparam logic [15:0] INT_MASK_ADDR = 16'h2101;
  localparam logic [15:0] MODE_STATUS_ADDR = 16'h2102;
  // field positions
  localparam int WATCHDOG_OVERFLOW_FLAG_POS = 2;
  localparam int REF_PAD_POS = 7;
  localparam int REF_DIS_POS = 3;
  localparam int ARM_POS = 7;
  localparam int SLEEP_CMD_POS = 6;
  localparam int UNIT_POS = 3;
  localparam int NEAR_POS = 0;
  localparam int BOOT_LOCK_POS = 5;
  localparam int CODE_LOCK_POS = 4;
  localparam int RESTART_POS = 7;
  // reset values
  localparam logic [2:0] PERIOD_RESET = 3'h1;
  localparam logic [3:0] FUSE_SEL_RESET = 4'h0;
  localparam logic [3:0] FUSE_SEL_REF_TRIM = 4'h1;
  localparam logic [7:0] REVISION_CODE = 8'h5A; // value is arbitrary
  // timing
  localparam int CLK_HZ = 125000000;
  localparam int UNIT_SHORT_MS = 2500;
  localparam int UNIT_LONG_MS = 60000;
  localparam longint UNIT_SHORT_CYC = longint'(CLK_HZ) * UNIT_SHORT_MS / 1000;
  localparam longint UNIT_LONG_CYC = longint'(CLK_HZ) * UNIT_LONG_MS / 1000;
  localparam int KIB = 1024;
  localparam int WD_LIMIT_CYC = 125000000;
  localparam int WD_NEAR_CYC = 125000;
  localparam int MEM_LAST_ADDR = 262143;
  // interrupt status bit positions
  localparam int EV_WAKE = 0;
  localparam int EV_NEAR = 1;
  localparam int EV_OVF = 2;
  localparam int EV_REFUSE = 3;
  localparam int EV_NUM = 4;
  typedef enum {RUN_ST, SLEEP_ST} power_state_type;
  typedef struct packed {
    logic req;
    logic [17:0] addr;
  } erase_req_type;
endpackage : wake_watchdog_trim_pkg

// ### core/wake_watchdog_trim_control_bank.sv
// register bank for trim select, revision, reference, autowake, watchdog flags and erase locks
`timescale 1ns/1ps
// ****************************************************************
// ****************************************************************
module wake_watchdog_trim_control_bank #(
  parameter longint UNIT_SHORT_CYCLES = wake_watchdog_trim_pkg::UNIT_SHORT_CYC,
  parameter longint UNIT_LONG_CYCLES = wake_watchdog_trim_pkg::UNIT_LONG_CYC,
  parameter int WD_LIMIT = wake_watchdog_trim_pkg::WD_LIMIT_CYC,
  parameter int WD_NEAR_MARGIN = wake_watchdog_trim_pkg::WD_NEAR_CYC,
  parameter int MEM_END = wake_watchdog_trim_pkg::MEM_LAST_ADDR
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic nv_rst_b_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [7:0] fuse_bytes_in [16],
  input wire logic mains_state_in,
  input wire logic brownout_state_in,
  input wire logic sys_power_in,
  input wire logic button_in,
  input wire logic reset_pin_in,
  input wire logic [7:0] boot_size_in,
  input wire logic [7:0] engine_code_base_in,
  input wire wake_watchdog_trim_pkg::erase_req_type erase_in,
  output logic erase_go_out,
  output logic erase_refused_out,
  output logic ref_enable_out,
  output logic ref_pad_out,
  output logic sleep_out,
  output logic wake_out,
  output logic rtc_unlock_out,
  output logic irq_out
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // mains and brownout are synchronised apart and merged only afterwards, so no glitch reaches a flop
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
    end else begin
      sync1_ff <= {brownout_state_in, button_in, reset_pin_in, sys_power_in, mains_state_in};
      sync2_ff <= sync1_ff;
    end
  end
  logic power_mode;
  logic power_present;
  logic pin_reset_high;
  logic button_sync;
  assign power_mode = sync2_ff[0] | sync2_ff[4];
  assign power_present = sync2_ff[1];
  assign pin_reset_high = sync2_ff[2];
  assign button_sync = sync2_ff[3];

  function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
    hit = (a == target);
  endfunction : hit

  logic wr_wd;
  logic wr_ref;
  logic wr_wake;
  logic wr_near;
  logic wr_sel;
  logic wr_lock;
  logic wr_restart;
  logic wr_unlock;
  logic wr_ist;
  logic wr_imask;
  assign wr_wd = wr_in && hit(addr_in, wake_watchdog_trim_pkg::WD_STATUS_ADDR);
  assign wr_ref = wr_in && hit(addr_in, wake_watchdog_trim_pkg::REF_CTRL_ADDR);
  assign wr_wake = wr_in && hit(addr_in, wake_watchdog_trim_pkg::WAKE_CTRL_ADDR);
  assign wr_near = wr_in && hit(addr_in, wake_watchdog_trim_pkg::NEAR_FLAG_ADDR);
  assign wr_sel = wr_in && hit(addr_in, wake_watchdog_trim_pkg::FUSE_SEL_ADDR);
  assign wr_lock = wr_in && hit(addr_in, wake_watchdog_trim_pkg::ERASE_LOCK_ADDR);
  assign wr_restart = wr_in && hit(addr_in, wake_watchdog_trim_pkg::WD_RESTART_ADDR);
  assign wr_unlock = wr_in && hit(addr_in, wake_watchdog_trim_pkg::RTC_UNLOCK_ADDR);
  assign wr_ist = wr_in && hit(addr_in, wake_watchdog_trim_pkg::INT_STATUS_ADDR);
  assign wr_imask = wr_in && hit(addr_in, wake_watchdog_trim_pkg::INT_MASK_ADDR);

  // ****************************************************************
  // control fields
  // ****************************************************************
  logic [3:0] fuse_byte_selector_ff;
  logic reference_pad_route_ff;
  logic reference_disable_bit_ff;
  logic [2:0] sleep_period_count_ff;
  logic sleep_period_unit_ff;
  logic boot_region_erase_lock_ff;
  logic code_region_erase_lock_ff;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fuse_byte_selector_ff <= wake_watchdog_trim_pkg::FUSE_SEL_RESET;
      reference_pad_route_ff <= 1'b0;
      reference_disable_bit_ff <= 1'b0;
      sleep_period_count_ff <= wake_watchdog_trim_pkg::PERIOD_RESET;
      sleep_period_unit_ff <= 1'b0;
      boot_region_erase_lock_ff <= 1'b0;
      code_region_erase_lock_ff <= 1'b0;
    end else begin
      if (wr_sel) begin
        fuse_byte_selector_ff <= wdata_in[3:0];
      end
      if (wr_ref) begin
        reference_pad_route_ff <= wdata_in[wake_watchdog_trim_pkg::REF_PAD_POS];
        reference_disable_bit_ff <= wdata_in[wake_watchdog_trim_pkg::REF_DIS_POS];
      end
      if (wr_wake) begin
        sleep_period_count_ff <= wdata_in[2:0];
        sleep_period_unit_ff <= wdata_in[wake_watchdog_trim_pkg::UNIT_POS];
      end
      if (wr_lock) begin
        boot_region_erase_lock_ff <= wdata_in[wake_watchdog_trim_pkg::BOOT_LOCK_POS];
        code_region_erase_lock_ff <= wdata_in[wake_watchdog_trim_pkg::CODE_LOCK_POS];
      end
    end
  end

  // reference outputs registered so the pad never sees a glitch from the bus decode
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ref_enable_out <= 1'b1;
      ref_pad_out <= 1'b0;
    end else begin
      ref_enable_out <= !reference_disable_bit_ff;
      ref_pad_out <= reference_pad_route_ff && !reference_disable_bit_ff;
    end
  end

  // ****************************************************************
  // autowake timer and sleep state
  // ****************************************************************
  logic armed_ff;
  logic [2:0] units_left_ff;
  logic unit_sel_ff;
  logic [39:0] cyc_left_ff;
  logic timeout;
  wake_watchdog_trim_pkg::power_state_type state_ff;
  logic [39:0] unit_len;
  assign unit_len = unit_sel_ff ? UNIT_LONG_CYCLES[39:0] : UNIT_SHORT_CYCLES[39:0];
  assign timeout = armed_ff && (units_left_ff == 3'h0);
  logic arm_wr;
  assign arm_wr = wr_wake && wdata_in[wake_watchdog_trim_pkg::ARM_POS];
  logic wake_event;
  // a zero count expires at once, so an arm with count zero is spent before any sleep can follow
  // limitation: a wake source still high keeps waking, so a later sleep command falls straight through
  assign wake_event = (state_ff == wake_watchdog_trim_pkg::SLEEP_ST) &&
                      (timeout || button_sync || power_present || pin_reset_high);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      armed_ff <= 1'b0;
      units_left_ff <= 3'h0;
      unit_sel_ff <= 1'b0;
      cyc_left_ff <= 40'h0;
    end else if (power_mode) begin
      armed_ff <= 1'b0;
      units_left_ff <= 3'h0;
      cyc_left_ff <= 40'h0;
    end else if (arm_wr) begin
      armed_ff <= 1'b1;
      units_left_ff <= wdata_in[2:0];
      unit_sel_ff <= wdata_in[wake_watchdog_trim_pkg::UNIT_POS];
      cyc_left_ff <= 40'h0;
    end else if (timeout) begin
      armed_ff <= 1'b0;
    end else if (armed_ff) begin
      if (cyc_left_ff >= unit_len - 40'h1) begin
        cyc_left_ff <= 40'h0;
        units_left_ff <= units_left_ff - 3'h1;
      end else begin
        cyc_left_ff <= cyc_left_ff + 40'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= wake_watchdog_trim_pkg::RUN_ST;
    end else begin
      case (state_ff)
        wake_watchdog_trim_pkg::RUN_ST: begin
          if (wr_wake && wdata_in[wake_watchdog_trim_pkg::SLEEP_CMD_POS] && !power_present) begin
            state_ff <= wake_watchdog_trim_pkg::SLEEP_ST;
          end
        end
        wake_watchdog_trim_pkg::SLEEP_ST: begin
          if (wake_event) begin
            state_ff <= wake_watchdog_trim_pkg::RUN_ST;
          end
        end
        default: state_ff <= wake_watchdog_trim_pkg::RUN_ST;
      endcase
    end
  end
  assign sleep_out = (state_ff == wake_watchdog_trim_pkg::SLEEP_ST);

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wake_out <= 1'b0;
    end else begin
      wake_out <= wake_event;
    end
  end

  // ****************************************************************
  // watchdog
  // ****************************************************************
  logic [31:0] wd_cnt_ff;
  logic wd_overflow;
  logic wd_near;
  logic wd_restart;
  logic near_flag_ff;
  logic ovf_flag_ff;
  // restart only on a whole-byte write with the top bit set; other writes to the byte do nothing
  assign wd_restart = wr_restart && wdata_in[wake_watchdog_trim_pkg::RESTART_POS];
  assign wd_overflow = (wd_cnt_ff == WD_LIMIT[31:0]);
  assign wd_near = (wd_cnt_ff == WD_LIMIT[31:0] - WD_NEAR_MARGIN[31:0]);
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wd_cnt_ff <= 32'h0;
    end else if (wd_restart || wd_overflow) begin
      wd_cnt_ff <= 32'h0;
    end else begin
      wd_cnt_ff <= wd_cnt_ff + 32'h1;
    end
  end

  // set wins over a wake or a write of zero landing in the same cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      near_flag_ff <= 1'b0;
    end else if (wd_near) begin
      near_flag_ff <= 1'b1;
    end else if (wake_event || (wr_near && !wdata_in[wake_watchdog_trim_pkg::NEAR_POS])) begin
      near_flag_ff <= 1'b0;
    end
  end

  // overflow flag lives on the nonvolatile reset, not the chip reset
  always_ff @(posedge clk_in or negedge nv_rst_b_in) begin
    if (!nv_rst_b_in) begin
      ovf_flag_ff <= 1'b0;
    end else if (wd_overflow) begin
      ovf_flag_ff <= 1'b1;
    end else if (pin_reset_high || (wr_wd && !wdata_in[wake_watchdog_trim_pkg::WATCHDOG_OVERFLOW_FLAG_POS])) begin
      ovf_flag_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // flash erase protection
  // ****************************************************************
  // the boot region stops just below its limit; the code region runs up to the last address
  logic [17:0] boot_top;
  logic [17:0] code_base;
  logic refuse;
  assign boot_top = 18'({boot_size_in, 10'h0});
  assign code_base = 18'({engine_code_base_in, 10'h0});
  assign refuse = (boot_region_erase_lock_ff && erase_in.addr < boot_top) ||
                  (code_region_erase_lock_ff && erase_in.addr >= code_base &&
                   erase_in.addr <= MEM_END[17:0]);
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      erase_go_out <= 1'b0;
      erase_refused_out <= 1'b0;
    end else begin
      erase_go_out <= erase_in.req && !refuse;
      erase_refused_out <= erase_in.req && refuse;
    end
  end

  // clock unlock strobe, one cycle per byte write
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rtc_unlock_out <= 1'b0;
    end else begin
      rtc_unlock_out <= wr_unlock;
    end
  end

  // ****************************************************************
  // interrupts
  // ****************************************************************
  logic [wake_watchdog_trim_pkg::EV_NUM-1:0] ist_ff;
  logic [wake_watchdog_trim_pkg::EV_NUM-1:0] imask_ff;
  logic [wake_watchdog_trim_pkg::EV_NUM-1:0] ev;
  always_comb begin
    ev = '0;
    ev[wake_watchdog_trim_pkg::EV_WAKE] = wake_event;
    ev[wake_watchdog_trim_pkg::EV_NEAR] = wd_near;
    ev[wake_watchdog_trim_pkg::EV_OVF] = wd_overflow;
    ev[wake_watchdog_trim_pkg::EV_REFUSE] = erase_in.req && refuse;
  end
  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ist_ff <= '0;
      imask_ff <= '0;
    end else begin
      ist_ff <= (ist_ff & ~(wr_ist ? wdata_in[wake_watchdog_trim_pkg::EV_NUM-1:0] : '0)) | ev;
      if (wr_imask) begin
        imask_ff <= wdata_in[wake_watchdog_trim_pkg::EV_NUM-1:0];
      end
    end
  end
  assign irq_out = |(ist_ff & imask_ff);

  // ****************************************************************
  // read port
  // ****************************************************************
  // unmapped and write-only addresses read as zero
  logic [7:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 8'h00;
    case (addr_in)
      wake_watchdog_trim_pkg::WD_STATUS_ADDR: nxt_rdata[wake_watchdog_trim_pkg::WATCHDOG_OVERFLOW_FLAG_POS] = ovf_flag_ff;
      wake_watchdog_trim_pkg::REF_CTRL_ADDR: begin
        nxt_rdata[wake_watchdog_trim_pkg::REF_PAD_POS] = reference_pad_route_ff;
        nxt_rdata[wake_watchdog_trim_pkg::REF_DIS_POS] = reference_disable_bit_ff;
      end
      wake_watchdog_trim_pkg::REVISION_ADDR: nxt_rdata = wake_watchdog_trim_pkg::REVISION_CODE;
      wake_watchdog_trim_pkg::WAKE_CTRL_ADDR: begin
        nxt_rdata[2:0] = sleep_period_count_ff;
        nxt_rdata[wake_watchdog_trim_pkg::UNIT_POS] = sleep_period_unit_ff;
      end
      wake_watchdog_trim_pkg::NEAR_FLAG_ADDR: nxt_rdata[wake_watchdog_trim_pkg::NEAR_POS] = near_flag_ff;
      wake_watchdog_trim_pkg::FUSE_SEL_ADDR: nxt_rdata[3:0] = fuse_byte_selector_ff;
      wake_watchdog_trim_pkg::FUSE_DATA_ADDR: nxt_rdata = fuse_bytes_in[fuse_byte_selector_ff];
      wake_watchdog_trim_pkg::ERASE_LOCK_ADDR: begin
        nxt_rdata[wake_watchdog_trim_pkg::BOOT_LOCK_POS] = boot_region_erase_lock_ff;
        nxt_rdata[wake_watchdog_trim_pkg::CODE_LOCK_POS] = code_region_erase_lock_ff;
      end
      wake_watchdog_trim_pkg::INT_STATUS_ADDR: nxt_rdata[wake_watchdog_trim_pkg::EV_NUM-1:0] = ist_ff;
      wake_watchdog_trim_pkg::INT_MASK_ADDR: nxt_rdata[wake_watchdog_trim_pkg::EV_NUM-1:0] = imask_ff;
      wake_watchdog_trim_pkg::MODE_STATUS_ADDR: nxt_rdata = {5'h0, sleep_out, armed_ff, power_present};
      default: nxt_rdata = 8'h00;
    endcase
  end
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= nxt_rdata;
    end else begin
      rdata_out <= 8'h00;
    end
  end
endmodule : wake_watchdog_trim_control_bank

// ### verification/wake_watchdog_trim_checker.sv
// port checks for the wake/watchdog/trim register bank
`timescale 1ns/1ps
module wake_watchdog_trim_checker (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic sys_power_in,
  input wire wake_watchdog_trim_pkg::erase_req_type erase_in,
  input wire logic erase_go_out,
  input wire logic erase_refused_out,
  input wire logic ref_enable_out,
  input wire logic ref_pad_out,
  input wire logic sleep_out,
  input wire logic rtc_unlock_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // ****************
  // bus steps
  // ****************
  sequence unlock_wr_s;
    wr_in && addr_in == wake_watchdog_trim_pkg::RTC_UNLOCK_ADDR;
  endsequence
  sequence ref_off_wr_s;
    wr_in && addr_in == wake_watchdog_trim_pkg::REF_CTRL_ADDR && wdata_in[wake_watchdog_trim_pkg::REF_DIS_POS];
  endsequence
  sequence rev_rd_s;
    rd_in && addr_in == wake_watchdog_trim_pkg::REVISION_ADDR;
  endsequence
  idle_read_a: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  rev_read_a: assert property (rev_rd_s |=> rdata_out == wake_watchdog_trim_pkg::REVISION_CODE)
    else $error("revision code wrong");
  unlock_pulse_a: assert property (unlock_wr_s |=> rtc_unlock_out)
    else $error("unlock pulse missing");
  unlock_quiet_a: assert property (!(wr_in && addr_in == wake_watchdog_trim_pkg::RTC_UNLOCK_ADDR) |=> !rtc_unlock_out)
    else $error("unlock pulse without write");
  erase_answer_a: assert property (erase_in.req |=> erase_go_out != erase_refused_out)
    else $error("erase request not answered once");
  erase_quiet_a: assert property (!erase_in.req |=> !erase_go_out && !erase_refused_out)
    else $error("erase answer without request");
  ref_off_a: assert property (ref_off_wr_s |-> ##2 !ref_enable_out && !ref_pad_out)
    else $error("reference still on after disable");
  power_hold_a: assert property (sys_power_in [*5] |-> !sleep_out)
    else $error("sleep entered with system power");
  reset_vals_a: assert property ($rose(rst_b_in) |-> ref_enable_out && !ref_pad_out && !sleep_out)
    else $error("outputs not at reset values");
endmodule : wake_watchdog_trim_checker

bind wake_watchdog_trim_control_bank wake_watchdog_trim_checker u_chk (.clk_in, .rst_b_in, .addr_in,
  .wdata_in, .wr_in, .rd_in, .rdata_out, .sys_power_in, .erase_in, .erase_go_out, .erase_refused_out,
  .ref_enable_out, .ref_pad_out, .sleep_out, .rtc_unlock_out);

// ### verification/wake_watchdog_trim_control_bank_bench.sv
// self-checking bench for the wake/watchdog/trim register bank
`timescale 1ns/1ps
module wake_watchdog_trim_control_bank_bench;
  localparam int U0 = 10;
  localparam int U1 = 20;
  localparam int WDL = 3000;
  localparam int WDM = 100;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic nv_rst_b_in = 1'b0;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] fuse_bytes_in [16];
  logic mains_state_in = 1'b0;
  logic brownout_state_in = 1'b0;
  logic sys_power_in = 1'b1;
  logic button_in = 1'b0;
  logic reset_pin_in = 1'b0;
  logic [7:0] boot_size_in = 8'h04;
  logic [7:0] engine_code_base_in = 8'hC8;
  wake_watchdog_trim_pkg::erase_req_type erase_in = '0;
  logic [7:0] rdata_out;
  logic erase_go_out, erase_refused_out, ref_enable_out, ref_pad_out;
  logic sleep_out, wake_out, rtc_unlock_out, irq_out, q;
  logic [31:0] seed = 32'h0000002B;
  logic [7:0] d, v;
  logic [2:0] c;
  logic [17:0] ea;
  int n, miscompares = 0, check_count = 0;
  always #4 clk_in = ~clk_in;
  wake_watchdog_trim_control_bank #(.UNIT_SHORT_CYCLES(U0), .UNIT_LONG_CYCLES(U1), .WD_LIMIT(WDL),
    .WD_NEAR_MARGIN(WDM), .MEM_END(262143)) u_wake_watchdog_trim_control_bank (.clk_in, .rst_b_in,
    .nv_rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .fuse_bytes_in, .mains_state_in,
    .brownout_state_in, .sys_power_in, .button_in, .reset_pin_in, .boot_size_in, .engine_code_base_in,
    .erase_in, .erase_go_out, .erase_refused_out, .ref_enable_out, .ref_pad_out, .sleep_out, .wake_out,
    .rtc_unlock_out, .irq_out);
  // ****************
  // helpers
  // ****************
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  function automatic logic refused(input logic [7:0] lk, input logic [17:0] a);
    return (lk[5] && a < 18'(boot_size_in) * 1024) || (lk[4] && a >= 18'(engine_code_base_in) * 1024);
  endfunction : refused
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask : cyc
  task automatic wr(input logic [15:0] a, input logic [7:0] x);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= x;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] x);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    x = rdata_out;
  endtask : rd
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // ****************
  // tests
  // ****************
  initial begin
    #(8 * 40000);
    miscompares++;
    print_verdict();
  end
  initial begin
    for (int i = 0; i < 16; i++) fuse_bytes_in[i] = rnd();
    repeat (20) @(posedge clk_in);
    rst_b_in <= 1'b1;
    nv_rst_b_in <= 1'b1;
    rd(16'h20A9, d);
    check(d & 8'h0F, 8'h01);
    rd(16'h2004, d);
    check(d, 8'h00);
    wr(16'h1234, rnd());
    rd(16'h1234, d);
    check(d, 8'h00);
    wr(16'h2006, rnd());
    rd(16'h2006, d);
    check(d, wake_watchdog_trim_pkg::REVISION_CODE);
    wr(16'h201F, rnd());
    check({7'h0, rtc_unlock_out}, 8'h01);
    $display("reset and identity test done");
    for (int i = 0; i < 16; i++) begin
      v = rnd();
      wr(16'h20FD, {v[7:4], 4'(i)});
      rd(16'h20FD, d);
      check(d & 8'h0F, 8'(i));
      rd(16'h20FF, d);
      check(d, fuse_bytes_in[i]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(16'h2004, {i[1], 3'h0, i[0], 3'h0});
      cyc(3);
      check({6'h0, ref_enable_out, ref_pad_out}, {6'h0, ~i[0], i[1] & ~i[0]});
    end
    $display("fuse and reference test done");
    wr(16'h00F8, 8'h80);
    for (int i = 0; i < 14; i++) begin
      v = (i < 5) ? 8'h30 : rnd() & 8'h30;
      ea = (i == 0) ? 18'h0 : (i == 1) ? 18'h00FFF : (i == 2) ? 18'h31FFF : (i == 3) ? 18'h32000 :
        (i == 4) ? 18'h3FFFF : 18'({rnd(), rnd(), rnd()});
      if (ea == 18'h01000) ea = 18'h01001;
      wr(16'h00B2, v);
      @(posedge clk_in);
      erase_in <= '{1'b1, ea};
      @(posedge clk_in);
      erase_in.req <= 1'b0;
      #1;
      check({6'h0, erase_go_out, erase_refused_out}, {6'h0, ~refused(v, ea), refused(v, ea)});
    end
    rd(16'h2100, d);
    check(d & 8'h08, 8'h08);
    wr(16'h2101, 8'h08);
    q = irq_out;
    wr(16'h2101, 8'h00);
    check({6'h0, q, irq_out}, 8'h02);
    wr(16'h2100, 8'h08);
    rd(16'h2100, d);
    check(d & 8'h08, 8'h00);
    $display("erase lock test done");
    sys_power_in <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      v = rnd();
      c = (k == 0) ? 3'h7 : 3'(v % 7 + 1);
      v[0] = (k == 0) | v[0];
      wr(16'h00F8, 8'h80);
      wr(16'h20A9, {1'b1, 3'h0, v[0], c});
      wr(16'h20A9, {2'b01, 2'h0, ~v[0], ~c});
      n = 2;
      cyc(2);
      check({7'h0, sleep_out}, 8'h01);
      rd(16'h2102, d);
      check(d, 8'h06);
      n = 6;
      while (wake_out !== 1'b1 && n < 400) begin
        cyc(1);
        n++;
      end
      check({7'h0, n >= c * (v[0] ? U1 : U0) && n <= c * (v[0] ? U1 : U0) + 1}, 8'h01);
      cyc(2);
      check({7'h0, sleep_out}, 8'h00);
    end
    for (int k = 0; k < 3; k++) begin
      sys_power_in <= (k == 0);
      mains_state_in <= (k == 1);
      brownout_state_in <= (k == 2);
      wr(16'h00F8, 8'h80);
      cyc(4);
      wr(16'h20A9, 8'h81);
      wr(16'h20A9, 8'h41);
      n = 0;
      repeat (40) begin
        cyc(1);
        n += wake_out;
      end
      check({7'h0, (k == 0) ? sleep_out : n != 0}, 8'h00);
      button_in <= 1'b1;
      cyc(4);
      button_in <= 1'b0;
    end
    sys_power_in <= 1'b0;
    mains_state_in <= 1'b0;
    brownout_state_in <= 1'b0;
    $display("autowake test done");
    wr(16'h00F8, 8'h80);
    cyc(WDL - WDM - 12);
    rd(16'h20B1, d);
    check(d & 8'h01, 8'h00);
    cyc(20);
    rd(16'h20B1, d);
    check(d & 8'h01, 8'h01);
    wr(16'h20A9, 8'h81);
    wr(16'h20A9, 8'h40);
    cyc(14);
    rd(16'h20B1, d);
    check(d & 8'h01, 8'h00);
    cyc(WDL + 20);
    rd(16'h2002, d);
    check(d & 8'h04, 8'h04);
    rd(16'h2100, d);
    check(d & 8'h07, 8'h07);
    rst_b_in <= 1'b0;
    cyc(3);
    rst_b_in <= 1'b1;
    rd(16'h2002, d);
    check(d & 8'h04, 8'h04);
    rd(16'h20FD, d);
    check(d, 8'h00);
    reset_pin_in <= 1'b1;
    cyc(4);
    reset_pin_in <= 1'b0;
    rd(16'h2002, d);
    check(d & 8'h04, 8'h00);
    $display("watchdog test done");
    print_verdict();
  end
endmodule : wake_watchdog_trim_control_bank_bench
